// *** hdl/can_mrt_pkg.sv ***
// register map, field positions and reset values for the mask, flag and buffer control block
package can_mrt_pkg;
  // word offsets (byte addresses) on the apb register bus
  localparam logic [7:0] MASK_STD_OFS0   = 8'h00; // three masks, standard part, stride 8
  localparam logic [7:0] MASK_EXT_OFS0   = 8'h04; // three masks, extended part, stride 8
  localparam logic [7:0] MASK_STRIDE     = 8'h08;
  localparam logic [7:0] FULL_LOW_OFS    = 8'h20;
  localparam logic [7:0] FULL_HIGH_OFS   = 8'h24;
  localparam logic [7:0] OVF_LOW_OFS     = 8'h28;
  localparam logic [7:0] OVF_HIGH_OFS    = 8'h2c;
  localparam logic [7:0] FMSK_SEL_OFS    = 8'h30; // filter mask source, 16 filters x 2 bits
  localparam logic [7:0] FILT_EXT_OFS    = 8'h34; // filter extended-select, 16 filters
  localparam logic [7:0] CTRL_OFS0       = 8'h40; // buffer pair control, four words
  // standard mask word fields
  localparam int        STD_SID_LSB      = 5;
  localparam int        STD_TYPE_BIT     = 3;
  localparam logic [15:0] STD_MASK_IMPL  = 16'hffeb; // bits 4 and 2 read as zero
  // buffer control byte fields
  localparam int        CTL_DIR_BIT      = 7;
  localparam int        CTL_ABT_BIT      = 6;
  localparam int        CTL_LARB_BIT     = 5;
  localparam int        CTL_ERR_BIT      = 4;
  localparam int        CTL_REQ_BIT      = 3;
  localparam int        CTL_RTR_BIT      = 2;
  localparam logic [15:0] FLAG_RESET     = 16'h0000;
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [1:0]  MASK_SRC_RSVD  = 2'h3;
  localparam int        NUM_MASKS        = 3;
  localparam int        NUM_CTL_BUFS     = 8;
  localparam int        NUM_FILTERS      = 16;
endpackage

// *** hdl/can_mask_rxflag_txctrl.sv ***
// acceptance masks, receive full/overflow flags and transmit buffer control with apb access
`timescale 1ns/1ns
`default_nettype none
module can_mask_rxflag_txctrl
  import can_mrt_pkg::*;
#(
  parameter int NUM_RX = 32
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // acceptance check from the protocol engine
  input  wire logic        flt_req_i,
  input  wire logic [3:0]  flt_idx_i,
  input  wire logic [10:0] msg_sid_i,
  input  wire logic [17:0] msg_eid_i,
  input  wire logic        msg_ext_i,
  input  wire logic [10:0] flt_sid_i,
  input  wire logic [17:0] flt_eid_i,
  output logic             flt_done_o,
  output logic             flt_match_o,
  // receive store event
  input  wire logic        rx_store_i,
  input  wire logic [4:0]  rx_buf_i,
  // transmit engine events, buffer index 0..7
  input  wire logic        tx_done_i,
  input  wire logic        tx_abort_done_i,
  input  wire logic        tx_arb_lost_i,
  input  wire logic        tx_bus_err_i,
  input  wire logic [2:0]  tx_buf_i,
  input  wire logic        remote_rx_i,
  input  wire logic [2:0]  remote_buf_i,
  // scheduling and control out
  output logic             tx_pending_o,
  output logic      [2:0]  tx_next_o,
  output logic      [7:0]  tx_abort_req_o,
  output logic      [7:0]  buf_is_tx_o
);

  // storage overview
  // the three acceptance masks are plain software registers with no reset,
  // so a filter that points at a mask never written compares against
  // unknown bits; software is expected to load every mask it selects
  // before it enables reception.
  // the full and overflow banks are 32 flags each, split over two 16-bit
  // words on the bus. hardware only ever sets them, and software only
  // ever clears them by writing zero; a one written back is harmless,
  // which lets software clear a single flag with a read-modify-write.
  // each buffer control byte mixes software fields (direction, request,
  // auto-remote, priority) with status flags that only hardware changes.
  logic [15:0]           mstd_q [NUM_MASKS]; // no reset: contents unknown after power-on
  logic [15:0]           mext_q [NUM_MASKS];
  logic [NUM_RX-1:0]     full_q;
  logic [NUM_RX-1:0]     ovf_q;
  logic [7:0]            ctl_q [NUM_CTL_BUFS];
  logic [31:0]           fsel_q;
  logic [15:0]           fext_q;

  logic                  wr_en;
  logic                  rd_en;
  logic [31:0]           rdata;
  logic                  addr_ok;

  // true for the four word-aligned control word addresses; the caller works out the register index
  function automatic logic is_ctl(input logic [7:0] a);
    return a >= CTRL_OFS0 && a < CTRL_OFS0 + 8'h10 && a[1:0] == 2'b00;
  endfunction

  // write-zero-to-clear update shared by both flag banks, set wins over clear
  function automatic logic [15:0] wzc(input logic [15:0] cur, input logic [15:0] wd,
                                      input logic [15:0] setv);
    return (cur & wd) | setv;
  endfunction

  // bus qualifiers
  // a write lands only at the edge where the access phase meets ready;
  // without the ready term a master that stretched its access phase
  // would apply the same write twice, which matters for the abort request
  // that is raised on the falling edge of a send request.
  assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
  assign rd_en = psel_i && penable_i && !pwrite_i && pready_o;

  // receive store decode
  // the protocol engine reports one stored message per cycle at most, so a
  // one-hot vector is enough; the overflow check below reuses it against
  // the full flags as they stood before this store.
  logic [NUM_RX-1:0] store_vec;
  assign store_vec = rx_store_i ? (NUM_RX'(1) << rx_buf_i) : '0;

  // mask registers, software only
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < NUM_MASKS; m++) begin
      if (wr_en && paddr_i == MASK_STD_OFS0 + 8'(m) * MASK_STRIDE) begin
        mstd_q[m] <= pwdata_i[15:0] & STD_MASK_IMPL;
      end
      if (wr_en && paddr_i == MASK_EXT_OFS0 + 8'(m) * MASK_STRIDE) begin
        mext_q[m] <= pwdata_i[15:0];
      end
    end
  end

  // filter mask source and extended-select words
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fsel_q <= 32'h0000_0000;
      fext_q <= 16'h0000;
    end else if (wr_en) begin
      if (paddr_i == FMSK_SEL_OFS) fsel_q <= pwdata_i;
      if (paddr_i == FILT_EXT_OFS) fext_q <= pwdata_i[15:0];
    end
  end

  // full flags: hardware set beats a software clear in the same cycle
  // the trade-off: software that clears a flag in the very cycle a new
  // message lands keeps seeing the buffer as full, which is the safe way
  // round, since losing a full indication would let the buffer be reused
  // before its message was read.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      full_q <= {FLAG_RESET, FLAG_RESET};
    end else begin
      full_q[15:0] <= wzc(full_q[15:0],
                          (wr_en && paddr_i == FULL_LOW_OFS) ? pwdata_i[15:0] : 16'hffff,
                          store_vec[15:0]);
      full_q[31:16] <= wzc(full_q[31:16],
                           (wr_en && paddr_i == FULL_HIGH_OFS) ? pwdata_i[15:0] : 16'hffff,
                           store_vec[31:16]);
    end
  end

  // overflow flags: store into a buffer already full
  // the first store into an empty buffer only sets its full flag; the
  // overflow flag needs a second store while the full flag still stands.
  logic [NUM_RX-1:0] ovf_set;
  assign ovf_set = store_vec & full_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_q <= {FLAG_RESET, FLAG_RESET};
    end else begin
      ovf_q[15:0] <= wzc(ovf_q[15:0],
                         (wr_en && paddr_i == OVF_LOW_OFS) ? pwdata_i[15:0] : 16'hffff,
                         ovf_set[15:0]);
      ovf_q[31:16] <= wzc(ovf_q[31:16],
                          (wr_en && paddr_i == OVF_HIGH_OFS) ? pwdata_i[15:0] : 16'hffff,
                          ovf_set[31:16]);
    end
  end

  // buffer control bytes; status bits are read-only to software
  // per buffer the next byte is built up in a local copy so that later
  // events in the same cycle override earlier ones in a fixed order:
  // software write, remote reply, transmit outcome, then the status clear
  // that goes with a fresh send request.
  // the abort request output is a level that stays up from the write that
  // dropped a pending request until the engine reports the abort done;
  // a buffer waiting for its abort is kept out of the scheduler.
  // limitation: a write that sets the request in the same cycle as a
  // completed send leaves the request cleared; software must retry.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int b = 0; b < NUM_CTL_BUFS; b++) ctl_q[b] <= CTL_RESET;
      tx_abort_req_o <= 8'h00;
    end else begin
      for (int b = 0; b < NUM_CTL_BUFS; b++) begin
        logic [7:0] c;
        logic [7:0] w;
        logic       req_set;
        c = ctl_q[b];
        w = pwdata_i[8*(b%2) +: 8];
        req_set = 1'b0;
        if (wr_en && paddr_i == CTRL_OFS0 + 8'(4 * (b / 2))) begin
          c[CTL_DIR_BIT] = w[CTL_DIR_BIT];
          c[CTL_RTR_BIT] = w[CTL_RTR_BIT];
          c[1:0]         = w[1:0];
          if (ctl_q[b][CTL_REQ_BIT] && !w[CTL_REQ_BIT]) begin
            tx_abort_req_o[b] <= 1'b1;
          end
          req_set = w[CTL_REQ_BIT] && !ctl_q[b][CTL_REQ_BIT];
          c[CTL_REQ_BIT] = w[CTL_REQ_BIT];
        end
        // remote frame reply request
        if (remote_rx_i && remote_buf_i == 3'(b) && ctl_q[b][CTL_RTR_BIT]) begin
          req_set = !ctl_q[b][CTL_REQ_BIT];
          c[CTL_REQ_BIT] = 1'b1;
        end
        // transmit engine outcomes for the active buffer
        if (tx_buf_i == 3'(b)) begin
          if (tx_arb_lost_i) c[CTL_LARB_BIT] = 1'b1;
          if (tx_bus_err_i)  c[CTL_ERR_BIT]  = 1'b1;
          if (tx_done_i) begin
            c[CTL_REQ_BIT] = 1'b0;
            c[CTL_ABT_BIT] = 1'b0;
          end
          if (tx_abort_done_i) begin
            c[CTL_ABT_BIT] = 1'b1;
            c[CTL_REQ_BIT] = 1'b0;
            tx_abort_req_o[b] <= 1'b0;
          end
        end
        if (req_set) begin
          c[CTL_ABT_BIT]  = 1'b0;
          c[CTL_LARB_BIT] = 1'b0;
          c[CTL_ERR_BIT]  = 1'b0;
        end
        ctl_q[b] <= c;
      end
    end
  end

  // priority pick: later index with equal priority wins by using >=
  // only transmit buffers with a standing request take part; the scan is
  // a short linear chain of eight comparators, cheap at this size, and its
  // result is registered so the engine sees a stable choice.
  logic       pick_v;
  logic [2:0] pick_i;
  logic [1:0] pick_p;
  always_comb begin
    pick_v = 1'b0;
    pick_i = 3'h0;
    pick_p = 2'h0;
    for (int b = 0; b < NUM_CTL_BUFS; b++) begin
      if (ctl_q[b][CTL_DIR_BIT] && ctl_q[b][CTL_REQ_BIT] && !tx_abort_req_o[b]
          && (!pick_v || ctl_q[b][1:0] >= pick_p)) begin
        pick_v = 1'b1;
        pick_i = 3'(b);
        pick_p = ctl_q[b][1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_pending_o <= 1'b0;
      tx_next_o    <= 3'h0;
      buf_is_tx_o  <= 8'h00;
    end else begin
      tx_pending_o <= pick_v;
      tx_next_o    <= pick_i;
      for (int b = 0; b < NUM_CTL_BUFS; b++) buf_is_tx_o[b] <= ctl_q[b][CTL_DIR_BIT];
    end
  end

  // acceptance comparison with the mask chosen by the filter
  // a mask bit of one makes the matching identifier bit take part, zero
  // makes it a don't-care. the standard word carries the eleven standard
  // bits, the type-match control and the top two extended bits; the
  // extended word carries the remaining sixteen extended bits.
  // with type matching on, the message format must agree with the
  // filter's extended select; with it off, a standard message needs only
  // the standard part and an extended one needs the whole identifier.
  // the compare is combinational and the answer is registered, so the
  // engine sees its result one cycle after the request.
  logic [1:0]  src;
  logic [15:0] ms;
  logic [15:0] me;
  logic [10:0] sid_m;
  logic [17:0] eid_m;
  logic        sid_eq;
  logic        eid_eq;
  logic        fx;
  logic        hit;
  always_comb begin
    src    = fsel_q[2*flt_idx_i +: 2];
    ms     = (src == 2'h1) ? mstd_q[1] : (src == 2'h2) ? mstd_q[2] : mstd_q[0];
    me     = (src == 2'h1) ? mext_q[1] : (src == 2'h2) ? mext_q[2] : mext_q[0];
    sid_m  = ms[15:STD_SID_LSB];
    eid_m  = {ms[1:0], me};
    sid_eq = ((msg_sid_i ^ flt_sid_i) & sid_m) == 11'h000;
    eid_eq = ((msg_eid_i ^ flt_eid_i) & eid_m) == 18'h00000;
    fx     = fext_q[flt_idx_i];
    if (ms[STD_TYPE_BIT]) begin
      hit = (msg_ext_i == fx) && sid_eq && (!fx || eid_eq);
    end else begin
      hit = sid_eq && (!msg_ext_i || eid_eq);
    end
    if (src == MASK_SRC_RSVD) hit = 1'b0; // reserved selection never matches
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt_done_o  <= 1'b0;
      flt_match_o <= 1'b0;
    end else begin
      flt_done_o  <= flt_req_i;
      flt_match_o <= flt_req_i && hit;
    end
  end

  // apb read mux
  // registers are 16 bits wide except the mask source word; unused upper
  // bits read as zero. an address outside the map reads zero and is
  // flagged as an error in the same cycle as ready.
  always_comb begin
    rdata   = 32'h0000_0000;
    addr_ok = 1'b1;
    if (is_ctl(paddr_i)) begin
      rdata[15:0] = {ctl_q[2*paddr_i[3:2]+1], ctl_q[2*paddr_i[3:2]]};
    end else begin
      case (paddr_i)
        8'h00, 8'h08, 8'h10: rdata[15:0] = mstd_q[paddr_i[4:3]];
        8'h04, 8'h0c, 8'h14: rdata[15:0] = mext_q[paddr_i[4:3]];
        FULL_LOW_OFS:  rdata[15:0] = full_q[15:0];
        FULL_HIGH_OFS: rdata[15:0] = full_q[31:16];
        OVF_LOW_OFS:   rdata[15:0] = ovf_q[15:0];
        OVF_HIGH_OFS:  rdata[15:0] = ovf_q[31:16];
        FMSK_SEL_OFS:  rdata       = fsel_q;
        FILT_EXT_OFS:  rdata[15:0] = fext_q;
        default:       addr_ok     = 1'b0;
      endcase
    end
  end

  // ready comes in the first access cycle: it is the setup cycle delayed
  // by one flop, so the answer is a one-cycle pulse and read data are
  // captured from the mux while the address is still held by the master.
  // keeping ready registered keeps the address decode off the bus path.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rdata : 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// *** verif/can_mrt_assertions.sv ***
// concurrent checks on the ports of the mask, flag and buffer control block
`timescale 1ns/1ns
`default_nettype none
module can_mrt_assertions #(
  parameter int NUM_RX = 32
) (
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pwrite_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       flt_req_i,
  input wire logic       flt_done_o,
  input wire logic       tx_abort_done_i,
  input wire logic [2:0] tx_buf_i,
  input wire logic [7:0] tx_abort_req_o,
  input wire logic [7:0] buf_is_tx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic wr;
  // a write lands at the edge where the access phase meets ready
  assign wr = psel_i && penable_i && pwrite_i && pready_o;
  a_flt_answer:
    assert property (flt_req_i |=> flt_done_o) else $error("filter answer missing");
  a_flt_quiet:
    assert property (!flt_req_i |=> !flt_done_o) else $error("filter answer unasked");
  a_apb_ready:
    assert property (psel_i && !penable_i |=> pready_o) else $error("ready late");
  a_ready_pulse:
    assert property (pready_o |=> !pready_o) else $error("ready held");
  a_err_ready:
    assert property (pslverr_o |-> pready_o) else $error("error without ready");
  // an abort request may only follow a software write, one or two cycles back
  a_abort_cause:
    assert property (|(tx_abort_req_o & ~$past(tx_abort_req_o)) |-> $past(wr) || $past(wr, 2))
    else $error("abort request without write");
  a_abort_clear:
    assert property (tx_abort_done_i && !wr && !$past(wr) |=> !tx_abort_req_o[$past(tx_buf_i)])
    else $error("abort request kept");
  a_dir_cause:
    assert property ($changed(buf_is_tx_o) |-> $past(wr) || $past(wr, 2))
    else $error("direction changed without write");
endmodule
`default_nettype wire

// *** verif/can_node_model.sv ***
// far-side stand-in: turns bench commands into protocol engine event pulses
`timescale 1ns/1ns
`default_nettype none
module can_node_model (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       go_i,
  input  wire logic [2:0] kind_i,
  input  wire logic [4:0] idx_i,
  output logic      [5:0] ev_o,
  output logic      [4:0] buf_o
);
  // one pulse per command; the index toggles when idle so a stale value never looks valid
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_o <= 6'h00;
      buf_o <= 5'h00;
    end else begin
      ev_o <= go_i ? 6'h01 << kind_i : 6'h00;
      buf_o <= go_i ? idx_i : ~buf_o;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the mask, flag and buffer control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import can_mrt_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, freq = 0, mext = 0, go = 0;
  logic [7:0]  paddr = 0, tabt, btx;
  logic [31:0] pwdata = 0, prdata, r, fsel;
  logic        pready, pslverr, fdone, fmatch, tpend, serr, x, exp;
  logic [3:0]  fidx = 0;
  logic [10:0] msid = 0, fsid = 0, s, gs;
  logic [17:0] meid = 0, feid = 0, e, ge;
  logic [2:0]  kind = 0, tnext;
  logic [4:0]  idx = 0, bufn;
  logic [5:0]  ev;
  logic [15:0] ms[3], me[3], fx;
  logic [1:0]  sel;
  int          seed = 32'haa487d9c, cyc = 0, checked = 0, err_count = 0, f;
  always #5 clk = ~clk;
  can_mask_rxflag_txctrl #(.NUM_RX(32)) dut (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .flt_req_i(freq),
    .flt_idx_i(fidx), .msg_sid_i(msid), .msg_eid_i(meid), .msg_ext_i(mext), .flt_sid_i(fsid),
    .flt_eid_i(feid), .flt_done_o(fdone), .flt_match_o(fmatch), .rx_store_i(ev[0]),
    .rx_buf_i(bufn), .tx_done_i(ev[1]), .tx_abort_done_i(ev[2]), .tx_arb_lost_i(ev[3]),
    .tx_bus_err_i(ev[4]), .tx_buf_i(bufn[2:0]), .remote_rx_i(ev[5]),
    .remote_buf_i(bufn[2:0]), .tx_pending_o(tpend), .tx_next_o(tnext),
    .tx_abort_req_o(tabt), .buf_is_tx_o(btx));
  can_node_model node (.clk_i(clk), .nrst_i(nrst), .go_i(go), .kind_i(kind), .idx_i(idx),
    .ev_o(ev), .buf_o(bufn));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // one apb transfer; ready and read data are taken at the rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    serr = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(r, want);
  endtask
  // kinds: 0 store, 1 sent, 2 abort done, 3 arbitration lost, 4 bus error, 5 remote
  task automatic evt(input logic [2:0] k, input logic [4:0] b);
    {go, kind, idx} <= {1'b1, k, b};
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd(8'(i < 4 ? 32 + 4 * i : 48 + 4 * i), 32'h0);
    // mask 1 forces type matching, masks 0 and 2 leave it off
    for (int m = 0; m < 3; m++) begin
      ms[m] = 16'($random(seed));
      ms[m][3] = m[0];
      me[m] = 16'($random(seed));
      apb(1'b1, 8'(MASK_STD_OFS0 + MASK_STRIDE * m), {16'h0, ms[m]});
      apb(1'b1, 8'(MASK_EXT_OFS0 + MASK_STRIDE * m), {16'h0, me[m]});
      rd(8'(MASK_STD_OFS0 + MASK_STRIDE * m), {16'h0, ms[m] & STD_MASK_IMPL});
      rd(8'(MASK_EXT_OFS0 + MASK_STRIDE * m), {16'h0, me[m]});
    end
    fsel = $random(seed);
    fx = 16'($random(seed));
    apb(1'b1, FMSK_SEL_OFS, fsel);
    apb(1'b1, FILT_EXT_OFS, {16'h0, fx});
    // sparse differences keep roughly a fifth of the compares matching
    for (int i = 0; i < 200; i++) begin
      f = $random(seed) & 15;
      gs = 11'($random(seed));
      ge = 18'($random(seed));
      s = gs ^ 11'($random(seed) & $random(seed) & $random(seed));
      e = ge ^ 18'($random(seed) & $random(seed) & $random(seed));
      x = 1'($random(seed));
      sel = fsel[2 * f +: 2];
      exp = sel < 3 && ((s ^ gs) & ms[sel][15:5]) == 0
        && (!x || ((e ^ ge) & {ms[sel][1:0], me[sel]}) == 0) && (!ms[sel][3] || x == fx[f]);
      {freq, fidx, msid, meid, mext, fsid, feid} <= {1'b1, f[3:0], s, e, x, gs, ge};
      @(posedge clk);
      freq <= 1'b0;
      @(negedge clk);
      chk({fdone, fmatch}, {1'b1, exp});
      @(posedge clk);
    end
    evt(3'h0, 5'd0);
    evt(3'h0, 5'd31);
    evt(3'h0, 5'd31);
    rd(FULL_LOW_OFS, 32'h1);
    rd(FULL_HIGH_OFS, 32'h8000);
    rd(OVF_LOW_OFS, 32'h0);
    rd(OVF_HIGH_OFS, 32'h8000);
    apb(1'b1, FULL_HIGH_OFS, 32'hffff);
    rd(FULL_HIGH_OFS, 32'h8000);
    apb(1'b1, FULL_HIGH_OFS, 32'h7fff);
    rd(FULL_HIGH_OFS, 32'h0);
    apb(1'b1, CTRL_OFS0, 32'h8b89);
    apb(1'b1, CTRL_OFS0 + 8'h4, 32'h008b);
    repeat (3) @(negedge clk);
    chk({tpend, tnext, btx}, {1'b1, 3'h2, 8'h07});
    evt(3'h1, 5'd2);
    rd(CTRL_OFS0 + 8'h4, 32'h0083);
    chk({tpend, tnext}, {1'b1, 3'h1});
    evt(3'h3, 5'd1);
    evt(3'h4, 5'd1);
    rd(CTRL_OFS0, 32'hbb89);
    apb(1'b1, CTRL_OFS0, 32'h8389);
    @(negedge clk);
    chk(tabt, 8'h02);
    evt(3'h2, 5'd1);
    rd(CTRL_OFS0, 32'hf389);
    chk(tabt, 8'h00);
    apb(1'b1, CTRL_OFS0, 32'h8b89);
    rd(CTRL_OFS0, 32'h8b89);
    apb(1'b1, CTRL_OFS0 + 8'h4, 32'h8087);
    evt(3'h5, 5'd2);
    evt(3'h5, 5'd3);
    rd(CTRL_OFS0 + 8'h4, 32'h808f);
    rd(8'hfc, 32'h0);
    chk(serr, 1'b1);
    final_report();
  end
endmodule
bind can_mask_rxflag_txctrl can_mrt_assertions #(.NUM_RX(NUM_RX)) checker_inst (.clk_i,
  .nrst_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .pslverr_o, .flt_req_i, .flt_done_o,
  .tx_abort_done_i, .tx_buf_i, .tx_abort_req_o, .buf_is_tx_o);
`default_nettype wire
